//--- rtl/mrp_checker.sv
// Purpose: Region protection checker between core accesses and the system bus
// Assumes: Region configuration is held stable while accesses are checked
// Notes: One access in flight; a check costs one cycle before the bus sees it
`timescale 1ns/100ps
`default_nettype none
module mrp_checker
  import mrp_pkg::*;
#(
  parameter int NUM_REGIONS = MRP_MAX_REGIONS
) (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire mrp_region_s [NUM_REGIONS-1:0] i_regions,
  input wire logic i_req_valid,
  input wire logic [MRP_ADDR_W-1:0] i_req_addr,
  input wire logic i_req_write,
  input wire logic [MRP_DATA_W-1:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_req_done,
  output logic o_req_error,
  output logic [MRP_DATA_W-1:0] o_req_rdata,
  output logic o_bus_valid,
  output logic [MRP_ADDR_W-1:0] o_bus_addr,
  output logic o_bus_write,
  output logic [MRP_DATA_W-1:0] o_bus_wdata,
  input wire logic i_bus_ready,
  input wire logic [MRP_DATA_W-1:0] i_bus_rdata,
  output logic o_fault,
  output logic [MRP_ADDR_W-1:0] o_fault_addr,
  output logic o_fault_write
);
  // ************************************************************
  // Parameter check
  // ************************************************************
  // The select index is three bits wide, so more regions cannot be served
  if (NUM_REGIONS < 1 || NUM_REGIONS > MRP_MAX_REGIONS) begin : g_bad_regions
    $error("NUM_REGIONS must be 1 to 8");
  end

  // ************************************************************
  // Region compare
  // ************************************************************
  logic [NUM_REGIONS-1:0] hit_vec;
  logic any_hit;
  logic [MRP_SUB_W-1:0] sel_idx;
  logic sel_no_access;
  logic sel_read_only;
  logic allowed;

  mrp_state_e state_r, state_nxt;
  logic [MRP_ADDR_W-1:0] addr_r, addr_nxt;
  logic write_r, write_nxt;
  logic [MRP_DATA_W-1:0] wdata_r, wdata_nxt;
  logic done_r, done_nxt;
  logic error_r, error_nxt;
  logic [MRP_DATA_W-1:0] rdata_r, rdata_nxt;
  logic fault_r, fault_nxt;
  logic [MRP_ADDR_W-1:0] faddr_r, faddr_nxt;
  logic fwrite_r, fwrite_nxt;

  genvar g;
  generate
    for (g = 0; g < NUM_REGIONS; g++) begin : g_region
      mrp_region_match u_match (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_region(i_regions[g]),
        .i_addr(addr_r),
        .o_hit(hit_vec[g])
      );
    end
  endgenerate

  // Config is read live, so changing it during a check changes the verdict
  // Overlaps resolve to the highest numbered region
  always_comb begin
    sel_idx = '0;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (hit_vec[i]) begin
        sel_idx = MRP_SUB_W'(i);
      end
    end
    any_hit = |hit_vec;
    sel_no_access = i_regions[sel_idx].no_access;
    sel_read_only = i_regions[sel_idx].read_only;
    allowed = any_hit
      && !sel_no_access
      && !(sel_read_only && write_r);
  end

  // ************************************************************
  // Access sequencing
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    write_nxt = write_r;
    wdata_nxt = wdata_r;
    done_nxt = 1'b0;
    error_nxt = error_r;
    rdata_nxt = rdata_r;
    fault_nxt = 1'b0;
    faddr_nxt = faddr_r;
    fwrite_nxt = fwrite_r;
    unique case (state_r)
      MRP_IDLE: begin
        if (i_req_valid) begin
          addr_nxt = i_req_addr;
          write_nxt = i_req_write;
          wdata_nxt = i_req_wdata;
          state_nxt = MRP_CHECK;
        end
      end
      MRP_CHECK: begin
        if (allowed) begin
          state_nxt = MRP_ISSUE;
        end else begin
          // Refused accesses end here and never touch the bus
          fault_nxt = 1'b1;
          faddr_nxt = addr_r;
          fwrite_nxt = write_r;
          done_nxt = 1'b1;
          error_nxt = 1'b1;
          rdata_nxt = '0;
          state_nxt = MRP_IDLE;
        end
      end
      MRP_ISSUE: begin
        if (i_bus_ready) begin
          done_nxt = 1'b1;
          error_nxt = 1'b0;
          rdata_nxt = write_r ? '0 : i_bus_rdata;
          state_nxt = MRP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_r <= MRP_IDLE;
      addr_r <= '0;
      write_r <= 1'b0;
      wdata_r <= '0;
      done_r <= 1'b0;
      error_r <= 1'b0;
      rdata_r <= '0;
      fault_r <= 1'b0;
      faddr_r <= '0;
      fwrite_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      write_r <= write_nxt;
      wdata_r <= wdata_nxt;
      done_r <= done_nxt;
      error_r <= error_nxt;
      rdata_r <= rdata_nxt;
      fault_r <= fault_nxt;
      faddr_r <= faddr_nxt;
      fwrite_r <= fwrite_nxt;
    end
  end

  assign o_req_ready = (state_r == MRP_IDLE);
  assign o_bus_valid = (state_r == MRP_ISSUE);
  assign o_bus_addr = addr_r;
  assign o_bus_write = write_r;
  assign o_bus_wdata = wdata_r;
  assign o_req_done = done_r;
  assign o_req_error = error_r;
  assign o_req_rdata = rdata_r;
  assign o_fault = fault_r;
  assign o_fault_addr = faddr_r;
  assign o_fault_write = fwrite_r;

  // ************************************************************
  // Checks
  // ************************************************************
  // Result checks restate the rules, except AST_REFUSED_RESULT and AST_REFUSED_OFF_BUS, which reuse the next-state term allowed
  AST_SEL_IN_RANGE: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_r == MRP_CHECK) && any_hit |-> hit_vec[sel_idx])
    else $error("selected region does not match the address");
  AST_NOHIT_FAULT: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_r == MRP_CHECK) && !any_hit |=> o_fault && (o_fault_addr == $past(addr_r)))
    else $error("unmapped access did not fault");
  AST_PERM_FAULT: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_r == MRP_CHECK) && any_hit && sel_read_only && write_r |=> o_fault && o_req_error)
    else $error("forbidden access type did not fault");
  AST_REFUSED_RESULT: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_r == MRP_CHECK) && !allowed |=>
      o_req_done && o_req_error && (o_fault_write == $past(write_r)))
    else $error("refused access ended without an error result");
  AST_GOOD_RESULT: assert property (@(posedge i_clock) disable iff (i_srst)
    o_bus_valid && i_bus_ready |=> o_req_done && !o_req_error && !o_fault)
    else $error("allowed access ended with a fault");
  AST_NO_ACCESS: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_r == MRP_CHECK) && any_hit && sel_no_access |=> o_fault ##1 !o_bus_valid)
    else $error("access to a closed region was let through");
  AST_RO_READ_OK: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_r == MRP_CHECK) && any_hit && !sel_no_access && !write_r |=> o_bus_valid && !o_fault)
    else $error("read of a readable region was refused");
  AST_REFUSED_OFF_BUS: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_r == MRP_CHECK) && !allowed |=> !o_bus_valid [*2])
    else $error("refused access reached the bus");
  AST_BUS_HOLD: assert property (@(posedge i_clock) disable iff (i_srst)
    o_bus_valid && !i_bus_ready |=> o_bus_valid && $stable(o_bus_addr) && $stable(o_bus_write))
    else $error("bus request dropped or changed before acceptance");

  COV_GOOD_WRITE: cover property (@(posedge i_clock) disable iff (i_srst)
    o_bus_valid && o_bus_write && i_bus_ready);
  COV_UNMAPPED: cover property (@(posedge i_clock) disable iff (i_srst)
    (state_r == MRP_CHECK) && !any_hit);
  COV_RO_WRITE: cover property (@(posedge i_clock) disable iff (i_srst)
    (state_r == MRP_CHECK) && any_hit && sel_read_only && write_r);
  COV_CLOSED: cover property (@(posedge i_clock) disable iff (i_srst)
    (state_r == MRP_CHECK) && any_hit && sel_no_access);
  COV_GOOD_READ: cover property (@(posedge i_clock) disable iff (i_srst)
    o_bus_valid && !o_bus_write && i_bus_ready);
endmodule
`default_nettype wire

//--- rtl/mrp_pkg.sv
// Purpose: Shared constants and types for the memory region protection checker
// Assumes: 32-bit byte addresses, configuration supplied as static inputs
// Notes: Constants, region struct and state enum only
`default_nettype none
package mrp_pkg;
  localparam int MRP_ADDR_W = 32;
  localparam int MRP_DATA_W = 32;
  localparam int MRP_MAX_REGIONS = 8;
  localparam int MRP_SUBS = 8;
  localparam int MRP_SUB_W = 3;
  localparam int MRP_SIZE_W = 5;
  // Smallest span is 2**8 bytes, so each sub-region holds at least 32 bytes
  localparam logic [MRP_SIZE_W-1:0] MRP_MIN_SIZE_LOG2 = 5'h08;

  typedef struct packed {
    logic enable;
    logic no_access;
    logic read_only;
    logic [MRP_SIZE_W-1:0] size_log2;
    logic [MRP_SUBS-1:0] sub_disable;
    logic [MRP_ADDR_W-1:0] base;
  } mrp_region_s;

  typedef enum logic [1:0] {
    MRP_IDLE,
    MRP_CHECK,
    MRP_ISSUE
  } mrp_state_e;
endpackage
`default_nettype wire

//--- rtl/mrp_region_match.sv
// Purpose: Address match of one protection region with sub-region masking
// Assumes: Region base is aligned to its span
// Notes: Purely combinational
`timescale 1ns/100ps
`default_nettype none
module mrp_region_match
  import mrp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_srst,
  input wire mrp_region_s i_region,
  input wire logic [MRP_ADDR_W-1:0] i_addr,
  output logic o_hit
);
  logic [MRP_ADDR_W-1:0] span_mask;
  logic [MRP_ADDR_W-1:0] shifted;
  logic [MRP_SUB_W-1:0] sub_idx;
  logic span_hit;
  logic size_ok;

  always_comb begin
    size_ok = (i_region.size_log2 >= MRP_MIN_SIZE_LOG2);
    span_mask = {MRP_ADDR_W{1'b1}} << i_region.size_log2;
    span_hit = ((i_addr & span_mask) == (i_region.base & span_mask));
    // Top three offset bits pick one of eight equal parts
    shifted = i_addr >> (i_region.size_log2 - MRP_SIZE_W'(MRP_SUB_W));
    sub_idx = shifted[MRP_SUB_W-1:0];
    o_hit = i_region.enable && size_ok && span_hit && !i_region.sub_disable[sub_idx];
  end

  AST_SUB_MASKED: assert property (@(posedge i_clock) disable iff (i_srst)
    i_region.sub_disable[sub_idx] |-> !o_hit)
    else $error("hit reported inside a disabled sub-region");
endmodule
`default_nettype wire

//--- tb/mrp_mem_model.sv
// Purpose: Bus-side word memory answering the checker's bus requests
// Assumes: Only address bits 11:2 decode, so higher addresses alias
// Notes: Waits 0 to 2 cycles per access; read data is scrambled when idle
`timescale 1ns/100ps
`default_nettype none
module mrp_mem_model
  import mrp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_valid,
  input wire logic [MRP_ADDR_W-1:0] i_addr,
  input wire logic i_write,
  input wire logic [MRP_DATA_W-1:0] i_wdata,
  output logic o_ready,
  output logic [MRP_DATA_W-1:0] o_rdata
);
  logic [MRP_DATA_W-1:0] mem [0:1023];
  int wait_n;
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = i;
    o_ready = 0;
    o_rdata = 32'h0;
    wait_n = 0;
  end
  always @(posedge i_clock) begin
    if (i_valid && o_ready && i_write) mem[i_addr[11:2]] = i_wdata;
    #1;
    if (o_ready || !i_valid) begin
      o_ready = 0;
      // Stale data is inverted each idle cycle, so every second cycle it shows the last read again
      o_rdata = ~o_rdata;
      wait_n = $urandom_range(2, 0);
    end else if (wait_n > 0) wait_n--;
    else begin
      o_ready = 1;
      o_rdata = mem[i_addr[11:2]];
    end
  end
endmodule
`default_nettype wire

//--- tb/mrp_checker_tb_top.sv
// Purpose: Self-checking bench for the region protection checker
// Assumes: Regions fixed after reset
// Notes: Driver queues notes, monitor compares on each done
`timescale 1ns/100ps
`default_nettype none
module mrp_checker_tb_top;
  import mrp_pkg::*;
  typedef struct packed {logic e; logic [31:0] rd; logic [31:0] a; logic w;
    logic [31:0] d;} mrp_note_s;
  logic i_clock = 0, i_srst = 1, i_req_valid = 0, i_req_write = 0;
  logic [31:0] i_req_addr = 0, i_req_wdata = 0, i_bus_rdata, o_req_rdata, o_bus_addr;
  logic [31:0] o_bus_wdata, o_fault_addr, ref_m [0:1023];
  logic o_req_ready, o_req_done, o_req_error, o_bus_valid, o_bus_write, i_bus_ready;
  logic o_fault, o_fault_write;
  mrp_region_s [7:0] i_regions;
  mrp_note_s notes [$], nt;
  int fail_count = 0, n_compared = 0;
  mrp_checker #(.NUM_REGIONS(8)) DUT (.i_clock(i_clock), .i_srst(i_srst),
    .i_regions(i_regions), .i_req_valid(i_req_valid), .i_req_addr(i_req_addr),
    .i_req_write(i_req_write), .i_req_wdata(i_req_wdata), .o_req_ready(o_req_ready),
    .o_req_done(o_req_done), .o_req_error(o_req_error), .o_req_rdata(o_req_rdata),
    .o_bus_valid(o_bus_valid), .o_bus_addr(o_bus_addr), .o_bus_write(o_bus_write),
    .o_bus_wdata(o_bus_wdata), .i_bus_ready(i_bus_ready), .i_bus_rdata(i_bus_rdata),
    .o_fault(o_fault), .o_fault_addr(o_fault_addr), .o_fault_write(o_fault_write));
  mrp_mem_model mem (.i_clock(i_clock), .i_valid(o_bus_valid), .i_addr(o_bus_addr),
    .i_write(o_bus_write), .i_wdata(o_bus_wdata), .o_ready(i_bus_ready),
    .o_rdata(i_bus_rdata));
  initial begin
    forever #50 i_clock = ~i_clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic access(input logic [31:0] a, input logic w, input logic [31:0] d,
                        input logic e);
    int n;
    n = 0;
    notes.push_back({e, (e | w) ? 32'h0 : ref_m[a[11:2]], a, w, d});
    if (w && !e) ref_m[a[11:2]] = d;
    while (o_req_ready !== 1'b1 && n < 50) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    if (n >= 50) chk(32'h1, 32'h0);
    i_req_valid = 1;
    i_req_addr = a;
    i_req_write = w;
    i_req_wdata = d;
    @(posedge i_clock);
    #1;
    i_req_valid = 0;
  endtask
  // ****************************************
  // Monitor
  // ****************************************
  always @(posedge i_clock) begin
    if (o_fault === 1'b1 && o_req_done !== 1'b1) chk(32'h1, 32'h0);
    // Oldest note is the access in flight while the bus completes it
    if (o_bus_valid === 1'b1 && i_bus_ready === 1'b1 && notes.size() > 0) begin
      chk(notes[0].e, 32'h0);
      chk(o_bus_addr, notes[0].a);
      chk(o_bus_write, notes[0].w);
      if (notes[0].w) chk(o_bus_wdata, notes[0].d);
    end
    if (o_req_done === 1'b1) begin
      nt = notes.pop_front();
      chk(o_req_error, nt.e);
      chk(o_fault, nt.e);
      chk(o_req_rdata, nt.rd);
      if (nt.e) chk(o_fault_addr, nt.a);
      if (nt.e) chk(o_fault_write, nt.w);
    end
  end
  initial begin
    #2000000;
    fail_count++;
    close_out();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    for (int i = 0; i < 1024; i++) ref_m[i] = i;
    i_regions = '0;
    i_regions[0] = '{1'b1, 1'b0, 1'b0, 5'h0C, 8'h00, 32'h0000_0000};
    i_regions[1] = '{1'b1, 1'b0, 1'b1, 5'h08, 8'h00, 32'h0000_0100};
    i_regions[2] = '{1'b1, 1'b1, 1'b0, 5'h08, 8'h00, 32'h0000_0200};
    i_regions[3] = '{1'b1, 1'b0, 1'b0, 5'h0A, 8'h04, 32'h0000_2000};
    i_regions[4] = '{1'b0, 1'b0, 1'b0, 5'h08, 8'h00, 32'h0000_3000};
    i_regions[7] = '{1'b1, 1'b0, 1'b1, 5'h08, 8'h00, 32'h0000_0800};
    void'($urandom(32'h76D4));
    repeat (20) @(posedge i_clock);
    #1;
    i_srst = 0;
    access(32'h0000_0104, 1'b0, 32'h0, 1'b0);
    access(32'h0000_0104, 1'b1, 32'hA5A5_0001, 1'b1);
    access(32'h0000_0104, 1'b0, 32'h0, 1'b0);
    access(32'h0000_0204, 1'b0, 32'h0, 1'b1);
    access(32'h0000_0208, 1'b1, 32'hA5A5_0002, 1'b1);
    access(32'h0001_0000, 1'b0, 32'h0, 1'b1);
    access(32'h0000_3004, 1'b1, 32'hA5A5_0003, 1'b1);
    access(32'h0000_2104, 1'b0, 32'h0, 1'b1);
    access(32'h0000_2084, 1'b1, 32'hA5A5_0004, 1'b0);
    access(32'h0000_2184, 1'b0, 32'h0, 1'b0);
    access(32'h0000_0804, 1'b1, 32'hA5A5_0005, 1'b1);
    access(32'h0000_0804, 1'b0, 32'h0, 1'b0);
    access(32'h0000_0904, 1'b1, 32'hA5A5_0006, 1'b0);
    access(32'h0000_0904, 1'b0, 32'h0, 1'b0);
    repeat (40) access({22'h0, 8'($urandom_range(63, 0)), 2'b00}, 1'($urandom), $urandom, 1'b0);
    repeat (30) @(posedge i_clock);
    #1;
    chk(notes.size(), 32'h0);
    // Second reset while idle, then one more access
    i_srst = 1;
    repeat (2) @(posedge i_clock);
    #1;
    i_srst = 0;
    chk(o_req_ready, 32'h1);
    chk(o_req_done, 32'h0);
    chk(o_bus_valid, 32'h0);
    chk(o_fault, 32'h0);
    access(32'h0000_0904, 1'b0, 32'h0, 1'b0);
    repeat (10) @(posedge i_clock);
    #1;
    chk(notes.size(), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
